// ==== design/tcf_flow.sv ====
// Configuration instruction sequencing with serial memory bridge.
`timescale 1ns/10ps

module tcf_flow #(
   parameter logic [tcf_pkg::IR_W-1:0] CODE_PROGRAM = tcf_pkg::CODE_PROGRAM,
   parameter logic [tcf_pkg::IR_W-1:0] CODE_STARTUP = tcf_pkg::CODE_STARTUP,
   parameter logic [tcf_pkg::IR_W-1:0] CODE_IO_LOAD = tcf_pkg::CODE_IO_LOAD,
   parameter logic [tcf_pkg::IR_W-1:0] CODE_RESTART = tcf_pkg::CODE_RESTART,
   parameter logic [tcf_pkg::IR_W-1:0] CODE_DISENGAGE = tcf_pkg::CODE_DISENGAGE,
   parameter logic [tcf_pkg::IR_W-1:0] CODE_ENGAGE = tcf_pkg::CODE_ENGAGE,
   parameter logic [tcf_pkg::IR_W-1:0] CODE_BRIDGE = tcf_pkg::CODE_BRIDGE,
   parameter int RESTART_HOLD_CYC = tcf_pkg::RESTART_HOLD_CYC,
   parameter int IO_LOAD_CYC = tcf_pkg::IO_LOAD_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tck,
   input wire tcf_pkg::tcf_tap_t tap,
   output logic tdo,
   output tcf_pkg::tcf_mem_t memPins,
   input wire logic memDataIn,
   input wire logic restartPinN,
   input wire logic [tcf_pkg::SCHEME_W-1:0] schemeSelect,
   input wire logic completeLineIn,
   input wire logic imageIsBridge,
   output logic configStatusNOut,
   output logic configStatusNOe,
   output logic userMode,
   output logic activeCtrlRun,
   output logic activeCtrlIdle,
   output logic ioChainReload,
   output logic userIoHiZ,
   output logic deviceReset,
   output logic bridgeActive
);
   import tcf_pkg::*;

   //------------------------------------------------------------------------
   // Helper functions
   //------------------------------------------------------------------------

   // Maps an instruction register code onto a crossing command.
   function automatic tcf_cmd_t decodeInstr(input logic [IR_W-1:0] code);
      tcf_cmd_t cmd;
      cmd = CMD_NONE;
      if (code == CODE_PROGRAM) begin
         cmd = CMD_PROGRAM;
      end else if (code == CODE_STARTUP) begin
         cmd = CMD_STARTUP;
      end else if (code == CODE_IO_LOAD) begin
         cmd = CMD_IO_LOAD;
      end else if (code == CODE_RESTART) begin
         cmd = CMD_RESTART;
      end else if (code == CODE_DISENGAGE) begin
         cmd = CMD_DISENGAGE;
      end else if (code == CODE_ENGAGE) begin
         cmd = CMD_ENGAGE;
      end
      return cmd;
   endfunction : decodeInstr

   // True when the scheme pins pick a scheme with an active controller.
   function automatic logic isActiveScheme(input logic [SCHEME_W-1:0] sch);
      return (sch == SCH_ACTIVE_SERIAL) || (sch == SCH_ACTIVE_PARALLEL);
   endfunction : isActiveScheme

   localparam int HOLD_W = $clog2(RESTART_HOLD_CYC + 1);
   localparam int IO_W = $clog2(IO_LOAD_CYC + 1);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RESTART_HOLD_CYC);
   localparam logic [IO_W-1:0] IO_LOAD = IO_W'(IO_LOAD_CYC);
   localparam int SYNC_W = 4 + SCHEME_W;

   //------------------------------------------------------------------------
   // Test clock domain
   //------------------------------------------------------------------------

   logic resetTckMeta; // First stage of the reset crossing.
   logic resetTck; // Reset as seen by the test clock logic.
   logic bridgeMeta; // First stage of the bridge flag crossing.
   logic bridgeTck; // Bridge flag as seen by the test clock logic.
   tcf_cmd_t cmdCode; // Last decoded command, held until the next one.
   logic cmdToggle; // Flips once for every command sent across.
   logic tapResetSeen; // Previous test-logic reset level, for edge finding.
   logic bridgeSel; // The bridge access instruction is current.
   logic memInMeta; // First stage of the memory data crossing.
   logic memInSync; // Memory data ready for the return path.
   logic shiftOn; // Bridge is moving data this test clock.

   // The config side reset reaches the test clock logic through two flops.
   // The test clock may stop, so reset only lands once the clock runs.
   always_ff @(posedge tck) begin
      resetTckMeta <= reset;
      resetTck <= resetTckMeta;
   end

   // The bridge state is a level; two flops are enough.
   always_ff @(posedge tck) begin
      bridgeMeta <= bridgeActive;
      bridgeTck <= bridgeMeta;
   end

   // Instructions are decoded when the instruction register updates.
   // A test-logic reset entry takes priority over a same-cycle update.
   always_ff @(posedge tck) begin
      if (resetTck) begin
         cmdCode <= CMD_NONE;
         cmdToggle <= 1'b0;
         tapResetSeen <= 1'b0;
         bridgeSel <= 1'b0;
      end else begin
         tapResetSeen <= tap.testLogicReset;
         if (tap.testLogicReset && !tapResetSeen) begin
            // Entering reset is passed on as its own command.
            cmdCode <= CMD_TAP_RESET;
            cmdToggle <= ~cmdToggle;
            bridgeSel <= 1'b0;
         end else if (tap.irUpdate) begin
            // Update time is the only point an instruction's command is taken; reset entry sends its own.
            bridgeSel <= (tap.irCode == CODE_BRIDGE);
            if (decodeInstr(tap.irCode) != CMD_NONE) begin
               cmdCode <= decodeInstr(tap.irCode);
               cmdToggle <= ~cmdToggle;
            end
         end
      end
   end

   // Bridge moves data only with its image loaded and its instruction current.
   assign shiftOn = bridgeSel && bridgeTck && tap.drShift;

   // Data from the scan port goes out to the memory, one bit per two test
   // clocks, so the memory clock rises with the data already stable.
   always_ff @(posedge tck) begin
      if (resetTck) begin
         memPins.memClk <= 1'b0;
         memPins.memChipSelN <= 1'b1;
         memPins.memDataOut <= 1'b0;
      end else if (shiftOn) begin
         if (memPins.memChipSelN) begin
            // First bit of a run is set up with the select.
            memPins.memChipSelN <= 1'b0;
            memPins.memDataOut <= tap.tdi;
         end else if (memPins.memClk) begin
            // Falling memory clock: present the next bit.
            memPins.memClk <= 1'b0;
            memPins.memDataOut <= tap.tdi;
         end else begin
            // Rising memory clock: the memory samples now.
            memPins.memClk <= 1'b1;
         end
      end else begin
         // Outside a run the memory is deselected and idle.
         memPins.memClk <= 1'b0;
         memPins.memChipSelN <= 1'b1;
      end
   end

   // Memory read data returns to the scan port through three flops.
   always_ff @(posedge tck) begin
      if (resetTck) begin
         memInMeta <= 1'b0;
         memInSync <= 1'b0;
         tdo <= 1'b0;
      end else begin
         memInMeta <= memDataIn;
         memInSync <= memInMeta;
         tdo <= shiftOn ? memInSync : 1'b0;
      end
   end

   //------------------------------------------------------------------------
   // Configuration clock domain: input crossings
   //------------------------------------------------------------------------

   logic [SYNC_W-1:0] syncMeta; // First flop of each pin crossing.
   logic [SYNC_W-1:0] syncOut; // Settled pin values.
   logic restartHigh; // Restart pin level, high means released.
   logic completeLine; // Complete line level.
   logic bridgeImage; // Image being loaded is the bridge.
   logic toggleSync; // Command toggle after crossing.
   logic [SCHEME_W-1:0] scheme; // Scheme pins after crossing.
   logic toggleSeen; // Toggle value already acted upon.
   logic cmdValid; // One-cycle pulse: a command has arrived.
   tcf_cmd_t cmdNow; // Command that arrived.

   // Every pin and the command toggle pass two flops before use.
   always_ff @(posedge clk) begin
      if (reset) begin
         syncMeta <= '0;
         syncOut <= '0;
      end else begin
         syncMeta <= {restartPinN, completeLineIn, imageIsBridge, cmdToggle, schemeSelect};
         syncOut <= syncMeta;
      end
   end

   assign {restartHigh, completeLine, bridgeImage, toggleSync, scheme} = syncOut;

   // The command code stays still for many test clocks after its toggle,
   // so it is safe to sample it once the toggle has settled here.
   always_ff @(posedge clk) begin
      if (reset) begin
         toggleSeen <= 1'b0;
         cmdValid <= 1'b0;
         cmdNow <= CMD_NONE;
      end else begin
         toggleSeen <= toggleSync;
         cmdValid <= toggleSync ^ toggleSeen;
         if (toggleSync ^ toggleSeen) begin
            cmdNow <= cmdCode;
         end
      end
   end

   //------------------------------------------------------------------------
   // Configuration clock domain: sequencing
   //------------------------------------------------------------------------

   tcf_state_t state; // Configuration state.
   logic [HOLD_W-1:0] holdCnt; // Cycles left in the restart hold.
   logic [IO_W-1:0] ioCnt; // Cycles left of an IO chain reload.
   logic disengaged; // Active controller parked in idle.
   logic programmed; // An image was loaded through the scan port.
   logic restartReq; // Instruction that asks for reconfiguration.
   logic goHold; // Any reason to restart now.
   logic goStartup; // Scan startup may bring the device to user mode.
   logic bridgeStart; // Bridge startup seen, shown one cycle later.

   // Both the restart and the re-engage instruction start reconfiguration;
   // in passive schemes re-engage therefore acts as the restart does.
   assign restartReq = cmdValid && ((cmdNow == CMD_RESTART) || (cmdNow == CMD_ENGAGE));
   // Nothing else restarts the device; a finished memory write does not.
   assign goHold = !restartHigh || restartReq;
   // A bridge image needs no released complete line to go to user mode.
   assign goStartup = cmdValid && (cmdNow == CMD_STARTUP) && programmed
      && (completeLine || bridgeImage);

   // Main state machine.
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_POWER_UP;
         holdCnt <= '0;
      end else begin
         unique case (state)
            ST_POWER_UP: begin
               // Leave power-up once the restart pin is high, or go straight to user mode on a scan startup.
               if (goStartup) begin
                  state <= ST_USER;
               end else if (restartHigh) begin
                  state <= ST_CONFIG;
               end
            end
            ST_CONFIG: begin
               if (goHold) begin
                  state <= ST_HOLD;
                  holdCnt <= HOLD_LOAD;
               end else if (goStartup) begin
                  state <= ST_USER;
               end else if (completeLine && !disengaged) begin
                  // An idled controller never finishes a load itself.
                  state <= ST_USER;
               end
            end
            ST_USER: begin
               if (goHold) begin
                  state <= ST_HOLD;
                  holdCnt <= HOLD_LOAD;
               end
            end
            ST_HOLD: begin
               // Hold while the pin is low, then for the fixed least time.
               if (!restartHigh) begin
                  holdCnt <= HOLD_LOAD;
               end else if (holdCnt == '0) begin
                  state <= ST_CONFIG;
               end else begin
                  holdCnt <= holdCnt - 1'b1;
               end
            end
         endcase
      end
   end

   // Remembers that a scan load happened; a restart forgets it.
   always_ff @(posedge clk) begin
      if (reset) begin
         programmed <= 1'b0;
      end else if (state == ST_HOLD) begin
         programmed <= 1'b0;
      end else if (cmdValid && (cmdNow == CMD_PROGRAM)) begin
         programmed <= 1'b1;
      end
   end

   // Bridge is armed at startup and shown in step with user mode; a restart wipes it.
   always_ff @(posedge clk) begin
      if (reset) begin
         bridgeStart <= 1'b0;
         bridgeActive <= 1'b0;
      end else begin
         bridgeStart <= goStartup && bridgeImage && !goHold;
         if (state == ST_HOLD) begin
            bridgeActive <= 1'b0;
         end else if (bridgeStart) begin
            bridgeActive <= 1'b1;
         end
      end
   end

   // Disengage and re-engage of the active controller. Only one command
   // arrives per cycle, so set and clear never meet.
   always_ff @(posedge clk) begin
      if (reset) begin
         disengaged <= 1'b0;
      end else if (cmdValid && (cmdNow == CMD_DISENGAGE)) begin
         // In passive schemes the request clears the idle flag instead of setting it.
         disengaged <= isActiveScheme(scheme);
      end else if (cmdValid && (cmdNow == CMD_ENGAGE)) begin
         disengaged <= 1'b0;
      end else if (cmdValid && (cmdNow == CMD_TAP_RESET) && (scheme == SCH_ACTIVE_SERIAL)) begin
         disengaged <= 1'b0;
      end else if (goStartup && (state != ST_HOLD)) begin
         // A scan load that reached user mode hands control back.
         disengaged <= 1'b0;
      end
   end

   // IO chain reload: a start pulse and a busy window with pins floated.
   // The reload leaves the status line alone on purpose.
   always_ff @(posedge clk) begin
      if (reset) begin
         ioCnt <= '0;
         ioChainReload <= 1'b0;
         userIoHiZ <= 1'b0;
      end else begin
         ioChainReload <= 1'b0;
         if (cmdValid && (cmdNow == CMD_IO_LOAD)) begin
            ioCnt <= IO_LOAD;
            ioChainReload <= 1'b1;
            userIoHiZ <= 1'b1;
         end else if (ioCnt != '0) begin
            ioCnt <= ioCnt - 1'b1;
         end else begin
            userIoHiZ <= 1'b0;
         end
      end
   end

   // Registered status outputs. The status line is pulled low only while
   // powering up or held in restart, never by an IO reload.
   always_ff @(posedge clk) begin
      if (reset) begin
         configStatusNOut <= 1'b0;
         configStatusNOe <= 1'b1;
         userMode <= 1'b0;
         activeCtrlRun <= 1'b0;
         activeCtrlIdle <= 1'b0;
         deviceReset <= 1'b0;
      end else begin
         configStatusNOut <= 1'b0;
         configStatusNOe <= (state == ST_HOLD) || (state == ST_POWER_UP);
         userMode <= (state == ST_USER);
         deviceReset <= (state == ST_HOLD);
         // An idled controller is kept from loading the device.
         activeCtrlRun <= (state == ST_CONFIG) && isActiveScheme(scheme) && !disengaged;
         activeCtrlIdle <= disengaged;
      end
   end

endmodule : tcf_flow

// ==== design/tcf_pkg.sv ====
// Shared constants, command codes and signal groups for the configuration instruction flow.
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package tcf_pkg;

   // Clock period of the configuration side.
   localparam int CLK_PERIOD_NS = 25;

   // Least time the device holds itself in reset after a restart request.
   localparam int RESTART_HOLD_NS = 500;
   localparam int RESTART_HOLD_CYC = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Time the IO setting chain takes to reload.
   localparam int IO_LOAD_NS = 10000;
   localparam int IO_LOAD_CYC = (IO_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Instruction register width and default instruction codes.
   localparam int IR_W = 10;
   localparam logic [IR_W-1:0] CODE_PROGRAM = 10'h002;
   localparam logic [IR_W-1:0] CODE_STARTUP = 10'h003;
   localparam logic [IR_W-1:0] CODE_IO_LOAD = 10'h00D;
   localparam logic [IR_W-1:0] CODE_RESTART = 10'h001;
   localparam logic [IR_W-1:0] CODE_DISENGAGE = 10'h2D0;
   localparam logic [IR_W-1:0] CODE_ENGAGE = 10'h2B0;
   localparam logic [IR_W-1:0] CODE_BRIDGE = 10'h00E;

   // Scheme select encodings.
   localparam int SCHEME_W = 2;
   localparam logic [SCHEME_W-1:0] SCH_PASSIVE_SERIAL = 2'h0;
   localparam logic [SCHEME_W-1:0] SCH_FAST_PASSIVE = 2'h1;
   localparam logic [SCHEME_W-1:0] SCH_ACTIVE_SERIAL = 2'h2;
   localparam logic [SCHEME_W-1:0] SCH_ACTIVE_PARALLEL = 2'h3;

   // Commands carried from the test clock side to the configuration side.
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_PROGRAM = 3'h1,
      CMD_STARTUP = 3'h2,
      CMD_IO_LOAD = 3'h3,
      CMD_RESTART = 3'h4,
      CMD_DISENGAGE = 3'h5,
      CMD_ENGAGE = 3'h6,
      CMD_TAP_RESET = 3'h7
   } tcf_cmd_t;

   // Configuration states, Gray coded along power-up, config, user, hold.
   typedef enum logic [1:0] {
      ST_POWER_UP = 2'h0,
      ST_CONFIG = 2'h1,
      ST_USER = 2'h3,
      ST_HOLD = 2'h2
   } tcf_state_t;

   // Test access port view handed in by the boundary-scan controller.
   typedef struct packed {
      logic testLogicReset;
      logic irUpdate;
      logic [IR_W-1:0] irCode;
      logic drShift;
      logic tdi;
   } tcf_tap_t;

   // Serial memory pins driven by the bridge.
   typedef struct packed {
      logic memClk;
      logic memChipSelN;
      logic memDataOut;
   } tcf_mem_t;

endpackage : tcf_pkg

// ==== test/tcf_flow_chk.sv ====
// Port-level assertions for the configuration instruction flow.
`timescale 1ns/10ps
module tcf_flow_chk #(
   parameter int RESTART_HOLD_CYC = 2,
   parameter int IO_LOAD_CYC = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tck,
   input wire tcf_pkg::tcf_tap_t tap,
   input wire tcf_pkg::tcf_mem_t memPins,
   input wire logic [tcf_pkg::SCHEME_W-1:0] schemeSelect,
   input wire logic configStatusNOe,
   input wire logic userMode,
   input wire logic activeCtrlIdle,
   input wire logic ioChainReload,
   input wire logic userIoHiZ,
   input wire logic deviceReset,
   input wire logic bridgeActive
);
   import tcf_pkg::*;
   int hizCnt; // Length of the current float run.
   int rstCnt; // Length of the current restart hold.
   // Run counters restart whenever the level drops.
   always_ff @(posedge clk) begin
      hizCnt <= (reset || !userIoHiZ) ? 0 : hizCnt + 1;
   end
   always_ff @(posedge clk) begin
      rstCnt <= (reset || !deviceReset) ? 0 : rstCnt + 1;
   end
   hiz_span_a: assert property (@(posedge clk) disable iff (reset)
      $fell(userIoHiZ) |-> hizCnt == IO_LOAD_CYC + 1) else $error("Float span wrong.");
   hiz_load_a: assert property (@(posedge clk) disable iff (reset)
      ioChainReload |-> ##[0:2] userIoHiZ) else $error("Pins not floated.");
   load_status_a: assert property (@(posedge clk) disable iff (reset)
      $rose(ioChainReload) && !configStatusNOe |=> !configStatusNOe [*8])
      else $error("Status held low by reload.");
   idle_scheme_a: assert property (@(posedge clk) disable iff (reset)
      activeCtrlIdle |-> schemeSelect[1]) else $error("Idle in passive scheme.");
   reset_out_a: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> configStatusNOe && !userMode && !bridgeActive)
      else $error("Outputs wrong at reset release.");
   hold_len_a: assert property (@(posedge clk) disable iff (reset)
      $fell(deviceReset) |-> rstCnt >= RESTART_HOLD_CYC) else $error("Restart hold short.");
   reset_bridge_a: assert property (@(posedge clk) disable iff (reset)
      deviceReset |-> !bridgeActive && !userMode) else $error("Bridge kept over restart.");
   bridge_user_a: assert property (@(posedge clk) disable iff (reset)
      bridgeActive |-> userMode) else $error("Bridge outside user mode.");
   mem_idle_a: assert property (@(posedge tck) disable iff (reset)
      !$past(tap.drShift) |-> memPins.memChipSelN && !memPins.memClk)
      else $error("Memory pins busy while idle.");
   mem_data_a: assert property (@(posedge tck) disable iff (reset)
      $rose(memPins.memClk) |-> memPins.memDataOut == $past(tap.tdi, 2))
      else $error("Memory data not forwarded.");
endmodule : tcf_flow_chk

bind tcf_flow tcf_flow_chk #(.RESTART_HOLD_CYC(RESTART_HOLD_CYC), .IO_LOAD_CYC(IO_LOAD_CYC))
   u_chk (.clk, .reset, .tck, .tap, .memPins, .schemeSelect, .configStatusNOe, .userMode,
   .activeCtrlIdle, .ioChainReload, .userIoHiZ, .deviceReset, .bridgeActive);

// ==== test/tcf_mem_model.sv ====
// Behavioural serial configuration memory that captures written bits.
`timescale 1ns/10ps
module tcf_mem_model (
   input wire logic memClk,
   input wire logic memChipSelN,
   input wire logic memDataOut,
   output logic memDataIn,
   output logic [7:0] rxByte
);
   logic lastBit = 1'b0; // Last bit driven, kept for the released line.
   initial rxByte = 8'h00;
   // Bits enter on the rising serial clock while selected.
   always @(posedge memClk) begin
      if (!memChipSelN) begin
         rxByte <= {rxByte[6:0], memDataOut};
      end
   end
   always @(rxByte or memChipSelN) begin
      if (!memChipSelN) begin
         lastBit = rxByte[7];
      end
   end
   // A deselected part leaves no stale value on its output.
   assign memDataIn = memChipSelN ? ~lastBit : rxByte[7];
endmodule : tcf_mem_model

// ==== test/tcf_flow_tb.sv ====
// Self-checking bench for the configuration instruction flow.
`timescale 1ns/10ps
module tcf_flow_tb;
   import tcf_pkg::*;
   localparam int IO_CYC = 4;
   logic clk = 1'b0;
   logic tck = 1'b0;
   logic reset = 1'b1;
   tcf_tap_t tap = '0;
   tcf_mem_t memPins;
   logic memDataIn;
   logic restartPinN = 1'b0;
   logic [SCHEME_W-1:0] schemeSelect = SCH_ACTIVE_SERIAL;
   logic completeLineIn = 1'b0;
   logic imageIsBridge = 1'b0;
   logic configStatusNOe, userMode, activeCtrlIdle, ioChainReload, userIoHiZ;
   logic deviceReset, bridgeActive;
   logic tdo, configStatusNOut, activeCtrlRun;
   logic [7:0] rxByte;
   int nMismatch = 0;
   int comparisons = 0;
   tcf_flow #(.RESTART_HOLD_CYC(2), .IO_LOAD_CYC(IO_CYC)) uut (.clk, .reset, .tck, .tap,
      .tdo, .memPins, .memDataIn, .restartPinN, .schemeSelect, .completeLineIn,
      .imageIsBridge, .configStatusNOut, .configStatusNOe, .userMode, .activeCtrlRun,
      .activeCtrlIdle, .ioChainReload, .userIoHiZ, .deviceReset, .bridgeActive);
   tcf_mem_model mem (.memClk(memPins.memClk), .memChipSelN(memPins.memChipSelN),
      .memDataOut(memPins.memDataOut), .memDataIn, .rxByte);
   // Test clock is offset so the two domains never line up.
   initial forever #12.5 clk = ~clk;
   initial begin
      #7;
      forever #40 tck = ~tck;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d.", comparisons, nMismatch);
      if (nMismatch == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   function automatic logic pick(input int s);
      case (s)
         0: return userMode;
         1: return ioChainReload;
         default: return deviceReset;
      endcase
   endfunction : pick
   // Bounded wait; running out ends the run as a failure.
   task automatic wait_for(input int s, input string what);
      int k;
      k = 0;
      while (pick(s) !== 1'b1 && k < 400) begin
         cyc(1);
         k++;
      end
      if (k >= 400) begin
         nMismatch++;
         $display("[ERR] %s never seen", what);
         close_out();
      end
   endtask : wait_for
   task automatic send(input logic [IR_W-1:0] code);
      @(posedge tck);
      #2 tap.irUpdate = 1'b1;
      tap.irCode = code;
      @(posedge tck);
      #2 tap.irUpdate = 1'b0;
   endtask : send
   task automatic issue(input logic [IR_W-1:0] code);
      send(code);
      cyc(14);
   endtask : issue
   task automatic power_up;
      cyc(16);
      reset = 1'b0;
      cyc(6);
      chk("status oe", configStatusNOe, 1);
      chk("status out", configStatusNOut, 0);
      restartPinN = 1'b1;
      completeLineIn = 1'b1;
      wait_for(0, "user");
      chk("status oe", configStatusNOe, 0);
   endtask : power_up
   task automatic io_load;
      cyc(9200);
      send(CODE_IO_LOAD);
      wait_for(1, "reload");
      chk("reload", ioChainReload, 1);
      cyc(1);
      chk("float", userIoHiZ, 1);
      cyc(IO_CYC + 4);
      chk("float", userIoHiZ, 0);
      chk("status oe", configStatusNOe, 0);
   endtask : io_load
   task automatic passive_idle;
      schemeSelect = SCH_PASSIVE_SERIAL;
      issue(CODE_DISENGAGE);
      chk("idle", activeCtrlIdle, 0);
      schemeSelect = SCH_FAST_PASSIVE;
      issue(CODE_DISENGAGE);
      chk("idle", activeCtrlIdle, 0);
      schemeSelect = SCH_ACTIVE_SERIAL;
   endtask : passive_idle
   task automatic tap_reset;
      issue(CODE_DISENGAGE);
      chk("idle", activeCtrlIdle, 1);
      @(posedge tck);
      #2 tap.testLogicReset = 1'b1;
      repeat (2) @(posedge tck);
      #2 tap.testLogicReset = 1'b0;
      cyc(14);
      chk("idle", activeCtrlIdle, 0);
      chk("restart", deviceReset, 0);
   endtask : tap_reset
   task automatic scan_program;
      issue(CODE_DISENGAGE);
      chk("idle", activeCtrlIdle, 1);
      issue(CODE_PROGRAM);
      issue(CODE_STARTUP);
      wait_for(0, "user");
      chk("idle", activeCtrlIdle, 0);
   endtask : scan_program
   task automatic engage_active;
      schemeSelect = SCH_ACTIVE_PARALLEL;
      issue(CODE_DISENGAGE);
      chk("idle", activeCtrlIdle, 1);
      send(CODE_ENGAGE);
      wait_for(2, "restart");
      cyc(2);
      chk("idle", activeCtrlIdle, 0);
      wait_for(0, "user");
   endtask : engage_active
   task automatic engage_passive;
      schemeSelect = SCH_PASSIVE_SERIAL;
      send(CODE_ENGAGE);
      wait_for(2, "restart");
      wait_for(0, "user");
   endtask : engage_passive
   task automatic bridge_write;
      logic [15:0] pat = 16'hA5A5;
      schemeSelect = SCH_ACTIVE_SERIAL;
      completeLineIn = 1'b0;
      imageIsBridge = 1'b1;
      send(CODE_RESTART);
      wait_for(2, "restart");
      cyc(20);
      chk("user", userMode, 0);
      chk("run", activeCtrlRun, 1);
      issue(CODE_DISENGAGE);
      chk("run", activeCtrlRun, 0);
      issue(CODE_PROGRAM);
      issue(CODE_STARTUP);
      chk("user", userMode, 1);
      chk("bridge", bridgeActive, 1);
      issue(CODE_BRIDGE);
      @(posedge tck);
      #2 tap.drShift = 1'b1;
      // Each memory bit is held for two test clocks; two bytes go out so the first
      // seven bits of the first byte stream back through the read path while the second is sent.
      for (int k = 0; k < 16; k++) begin
         tap.tdi = pat[15 - k];
         repeat (2) @(posedge tck);
         #2;
         // Read data trails the written stream by nine memory bits.
         if (k >= 9) begin
            chk("read", tdo, pat[24 - k]);
         end
      end
      tap.drShift = 1'b0;
      cyc(8);
      chk("memory", rxByte, 8'hA5);
      cyc(40);
      chk("user", userMode, 1);
      send(CODE_RESTART);
      wait_for(2, "restart");
      chk("bridge", bridgeActive, 0);
   endtask : bridge_write
   initial begin
      power_up();
      io_load();
      passive_idle();
      tap_reset();
      scan_program();
      engage_active();
      engage_passive();
      bridge_write();
      close_out();
   end
endmodule : tcf_flow_tb
